// ### verilog/cocd_decoder.sv
// code option configuration decoder with apb read-back
//
// Operation
// - reset speed bit picks green or normal
// - power tier bit picks low or high
// - brown-out resets only after qualifying dip time
// - reset pin select enables reset, clears pullup
// - watchdog enable bit is active low
// - glitch select picks 8 or 32 periods
// - low crystal mode forces 8 period width
// - filter enable, forced off in low modes
// - protect all zero on, all one off
// - sub oscillator select crystal or rc
// - watchdog clock always 16kHz
// - fast rc trim applied to main rc
// - fast rc frequency field selects frequency
// - main oscillator field selects crystal or rc
// - clock out bit drives cycle clock, in rc main oscillator modes only
// - slow rc trim applied to sub rc
// - rc reference bandgap or regulator
// - i2c pins beside uart or spi
// - low pass strength heavy or light
// - adc alignment picks result layout
// - aligned low layout clears high nibble
`timescale 1ns/1ps
`include "cocd_defines.svh"

module cocd_decoder (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // programmed option words from the one-time memory
    input wire logic [14:0] otp_word0,
    input wire logic [14:0] otp_word1,
    input wire logic [14:0] otp_word2,
    input wire logic [14:0] otp_word3,
    // live system inputs
    input wire cocd_pkg::cocd_cpu_mode_t cpu_mode,
    input wire logic supply_below_trip,
    input wire logic [11:0] adc_result,
    // power, reset and watchdog settings
    output logic reset_speed_select,
    output logic power_tier_select,
    output logic [1:0] brownout_level_select,
    output logic brownout_enable,
    output logic brownout_reset,
    output logic ext_reset_pin_select,
    output logic pin57_pullup_ctl_init,
    output logic watchdog_enable,
    output logic watchdog_clk_16k,
    // noise filter
    output logic glitch_filter_on,
    output logic [5:0] glitch_width,
    // protection
    output logic code_protect,
    // oscillators
    output logic sub_crystal_mode,
    output logic sub_rc_32k,
    output logic sub_pins_io,
    output logic [5:0] fast_rc_trim,
    output logic [1:0] fast_rc_freq_select,
    output logic [2:0] main_osc_select,
    output logic main_is_rc,
    output logic clock_out_pin_io,
    output logic clock_out_enable,
    output logic [3:0] slow_rc_trim,
    output logic rc_reference_select,
    // routing, filter, adc
    output logic i2c_pin_route,
    output logic input_lowpass_strength,
    output logic adc_result_align,
    output logic [7:0] adc_result_high,
    output logic [7:0] adc_result_low,
    output logic [5:0] customer_tag
);
    import cocd_pkg::*;

    // ======================================================
    // state record
    typedef struct packed {
        logic [14:0] w0;              // captured power/reset word
        logic [14:0] w1;              // captured oscillator word
        logic [14:0] w2;              // captured trim/routing word
        logic [14:0] w3;              // captured filter/adc word
        logic loaded;                 // words have been captured
        cocd_bor_state_t bor_st;      // brown-out qualify state
        logic [`COCD_BOR_CNT_W-1:0] bor_cnt; // dip length counter
        logic bor_rst;                // qualified brown-out reset
        logic filt_on;                // effective filter enable
        logic [5:0] filt_w;           // effective filter width
        logic [7:0] adc_hi;           // aligned high result
        logic [7:0] adc_lo;           // aligned low result
        logic [31:0] rdata;           // apb read data
        logic rdy;                    // apb ready
        logic err;                    // apb slave error
    } cocd_state_t;

    cocd_state_t st;
    cocd_state_t next_st;

    // reset image: unprogrammed defaults, nothing else qualified
    localparam cocd_state_t COCD_RESET_ST = '{
        w0: `COCD_W0_RESET, w1: `COCD_W1_RESET,
        w2: `COCD_W2_RESET, w3: `COCD_W3_RESET,
        loaded: 1'b0, bor_st: COCD_BOR_OK,
        bor_cnt: '0, bor_rst: 1'b0, filt_on: 1'b0,
        filt_w: `COCD_GLITCH_LONG, adc_hi: 8'h00, adc_lo: 8'h00,
        rdata: 32'h0000_0000, rdy: 1'b0, err: 1'b0
    };

    localparam logic [`COCD_BOR_CNT_W-1:0] COCD_BOR_LAST =
        `COCD_BOR_CNT_W'(`COCD_BOR_QUAL_CYC - 1);

    // ======================================================
    // combinational next state
    always_comb begin
        logic low_mode;
        logic lxt;
        logic bor_on;
        logic setup;
        low_mode = 1'b0;
        lxt = 1'b0;
        bor_on = 1'b0;
        setup = 1'b0;
        next_st = st;

        // capture on the first clock after release, then hold;
        // the words are never writable over the bus
        if (!st.loaded) begin
            next_st.w0 = otp_word0;
            next_st.w1 = otp_word1;
            next_st.w2 = otp_word2;
            next_st.w3 = otp_word3;
            next_st.loaded = 1'b1;
        end

        // brown-out: only a dip held for the full time trips
        bor_on = (st.w0[`COCD_W0_BOR_HI:`COCD_W0_BOR_LO] != 2'h3);
        case (st.bor_st)
            COCD_BOR_OK: begin
                next_st.bor_cnt = '0;
                if (bor_on && supply_below_trip) begin
                    next_st.bor_st = COCD_BOR_DIP;
                end
            end
            COCD_BOR_DIP: begin
                // a short dip returns to ok without reset
                if (!bor_on || !supply_below_trip) begin
                    next_st.bor_st = COCD_BOR_OK;
                end else if (st.bor_cnt == COCD_BOR_LAST) begin
                    next_st.bor_st = COCD_BOR_TRIP;
                end else begin
                    next_st.bor_cnt = st.bor_cnt + 1'b1;
                end
            end
            COCD_BOR_TRIP: begin
                // hold reset request until supply recovers
                if (!bor_on || !supply_below_trip) begin
                    next_st.bor_st = COCD_BOR_OK;
                end
            end
            default: begin
                next_st.bor_st = COCD_BOR_OK;
            end
        endcase
        next_st.bor_rst = (next_st.bor_st == COCD_BOR_TRIP);

        // noise filter: off in green, idle and sleep
        low_mode = (cpu_mode != COCD_CPU_NORMAL);
        next_st.filt_on = st.w0[`COCD_W0_NRE] && !low_mode;
        lxt = (st.w1[`COCD_W1_OSC_HI:`COCD_W1_OSC_LO] == COCD_OSC_LOW_CRYSTAL_ONE_MODE);
        if (lxt || !st.w0[`COCD_W0_GLITCH]) begin
            next_st.filt_w = `COCD_GLITCH_SHORT;
        end else begin
            next_st.filt_w = `COCD_GLITCH_LONG;
        end

        // adc result layout
        if (st.w3[`COCD_W3_ADC_RESULT_ALIGN]) begin
            next_st.adc_hi = adc_result[11:4];
            next_st.adc_lo = {4'h0, adc_result[3:0]};
        end else begin
            next_st.adc_hi = {4'h0, adc_result[11:8]};
            next_st.adc_lo = adc_result[7:0];
        end

        // apb: zero wait, answer in the access cycle
        setup = psel && !penable;
        next_st.rdy = setup;
        next_st.err = 1'b0;
        next_st.rdata = 32'h0000_0000;
        if (setup) begin
            case (paddr)
                `COCD_ADDR_WORD0: next_st.rdata = {17'h0, st.w0};
                `COCD_ADDR_WORD1: next_st.rdata = {17'h0, st.w1};
                `COCD_ADDR_WORD2: next_st.rdata = {17'h0, st.w2};
                `COCD_ADDR_WORD3: next_st.rdata = {17'h0, st.w3};
                `COCD_ADDR_STATUS: begin
                    next_st.rdata = {25'h0, st.filt_w, st.bor_rst};
                end
                `COCD_ADDR_ADCOUT: begin
                    next_st.rdata = {16'h0, st.adc_hi, st.adc_lo};
                end
                default: begin
                    // unmapped address
                    next_st.err = 1'b1;
                end
            endcase
            // every register is read only: writes are refused
            if (pwrite) begin
                next_st.err = 1'b1;
                next_st.rdata = 32'h0000_0000;
            end
        end
    end

    // ======================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= COCD_RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================
    // decoded settings from the captured flops; watchdog_clk_16k is tied high
    assign reset_speed_select = st.w0[`COCD_W0_SPEED];
    assign power_tier_select = st.w0[`COCD_W0_POWER];
    assign brownout_level_select =
        st.w0[`COCD_W0_BOR_HI:`COCD_W0_BOR_LO];
    assign brownout_enable = st.w0[`COCD_W0_BOR_HI] &
        st.w0[`COCD_W0_BOR_LO] ? 1'b0 : 1'b1;
    assign brownout_reset = st.bor_rst;
    assign ext_reset_pin_select = st.w0[`COCD_W0_RSTPIN];
    // pull-high initial value follows the select: 0 enables it
    assign pin57_pullup_ctl_init = st.w0[`COCD_W0_RSTPIN];
    assign watchdog_enable = ~st.w0[`COCD_W0_WDT_N];
    // the watchdog always runs from the 16k rc, never the sub clock
    assign watchdog_clk_16k = 1'b1;
    assign glitch_filter_on = st.filt_on;
    assign glitch_width = st.filt_w;
    // only the all-zero code protects; mixed codes leave it open
    assign code_protect =
        (st.w0[`COCD_W0_PR_HI:`COCD_W0_PR_LO] == `COCD_PROT_ON);
    assign sub_crystal_mode = ~st.w1[`COCD_W1_FSS_HI];
    assign sub_rc_32k = st.w1[`COCD_W1_FSS_HI] &
        ~st.w1[`COCD_W1_FSS_LO];
    assign sub_pins_io = st.w1[`COCD_W1_FSS_HI];
    assign fast_rc_trim = st.w1[`COCD_W1_TRIM_HI:`COCD_W1_TRIM_LO];
    assign fast_rc_freq_select =
        st.w1[`COCD_W1_RCM_HI:`COCD_W1_RCM_LO];
    assign main_osc_select = st.w1[`COCD_W1_OSC_HI:`COCD_W1_OSC_LO];
    assign main_is_rc = ~st.w1[`COCD_W1_OSC_HI];
    assign clock_out_pin_io = ~st.w1[`COCD_W1_OSC_HI] &
        st.w1[`COCD_W1_OSC_LO];
    // outside rc mode the bit has no effect
    assign clock_out_enable = ~st.w1[`COCD_W1_OSC_HI] &
        st.w1[`COCD_W1_CKOUT];
    assign slow_rc_trim = st.w2[`COCD_W2_SRC_HI:`COCD_W2_SRC_LO];
    assign rc_reference_select = st.w2[`COCD_W2_REF];
    assign i2c_pin_route = st.w2[`COCD_W2_I2C];
    assign input_lowpass_strength = st.w3[`COCD_W3_LPF];
    assign adc_result_align = st.w3[`COCD_W3_ADC_RESULT_ALIGN];
    assign adc_result_high = st.adc_hi;
    assign adc_result_low = st.adc_lo;
    assign customer_tag = st.w3[`COCD_W3_TAG_HI:`COCD_W3_TAG_LO];

    // apb answer
    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.err;
endmodule

// ### verilog/cocd_defines.svh
// constants for the code option configuration decoder
`ifndef COCD_DEFINES_SVH
`define COCD_DEFINES_SVH
// ======================================================
// register byte addresses (one aligned word each)
`define COCD_ADDR_WORD0 12'h000
`define COCD_ADDR_WORD1 12'h004
`define COCD_ADDR_WORD2 12'h008
`define COCD_ADDR_WORD3 12'h00C
`define COCD_ADDR_STATUS 12'h010
`define COCD_ADDR_ADCRAW 12'h014
`define COCD_ADDR_ADCOUT 12'h018
// ======================================================
// word 0 field positions
`define COCD_W0_SPEED 10
`define COCD_W0_POWER 9
`define COCD_W0_BOR_HI 8
`define COCD_W0_BOR_LO 7
`define COCD_W0_RSTPIN 6
`define COCD_W0_WDT_N 5
`define COCD_W0_GLITCH 4
`define COCD_W0_NRE 3
`define COCD_W0_PR_HI 2
`define COCD_W0_PR_LO 0
`define COCD_W0_SPARE_HI 14
`define COCD_W0_SPARE_LO 11
// word 1 field positions
`define COCD_W1_FSS_HI 14
`define COCD_W1_FSS_LO 13
`define COCD_W1_TRIM_HI 12
`define COCD_W1_TRIM_LO 7
`define COCD_W1_RCM_HI 6
`define COCD_W1_RCM_LO 5
`define COCD_W1_OSC_HI 3
`define COCD_W1_OSC_LO 1
`define COCD_W1_CKOUT 0
// word 2 field positions
`define COCD_W2_SRC_HI 11
`define COCD_W2_SRC_LO 8
`define COCD_W2_REF 6
`define COCD_W2_I2C 4
// word 3 field positions
`define COCD_W3_LPF 14
`define COCD_W3_ADC_RESULT_ALIGN 11
`define COCD_W3_TAG_HI 5
`define COCD_W3_TAG_LO 0
// ======================================================
// reset values of the captured words (the unprogrammed defaults)
`define COCD_W0_RESET 15'h7DFF
`define COCD_W1_RESET 15'h7FF7
`define COCD_W2_RESET 15'h3FD2
`define COCD_W3_RESET 15'h7FFF
// ======================================================
// brown-out qualifying time and derived cycle count
`define COCD_BOR_QUAL_NS 5000
`define COCD_CLK_PERIOD_NS 5
`define COCD_BOR_QUAL_CYC (`COCD_BOR_QUAL_NS / `COCD_CLK_PERIOD_NS)
`define COCD_BOR_CNT_W 10
// glitch filter widths in main-clock periods
`define COCD_GLITCH_SHORT 6'h08
`define COCD_GLITCH_LONG 6'h20
// protection codes
`define COCD_PROT_ON 3'h0
`define COCD_PROT_OFF 3'h7
`endif

// ### verilog/cocd_pkg.sv
// types shared by the code option configuration decoder
package cocd_pkg;
    // cpu operating modes as reported by the core
    typedef enum logic [1:0] {
        COCD_CPU_NORMAL = 2'h0,
        COCD_CPU_GREEN = 2'h1,
        COCD_CPU_IDLE = 2'h3,
        COCD_CPU_SLEEP = 2'h2
    } cocd_cpu_mode_t;
    // main oscillator modes
    typedef enum logic [2:0] {
        COCD_OSC_IRC_CKOUT = 3'h0,
        COCD_OSC_IRC_IO = 3'h1,
        COCD_OSC_LOW_CRYSTAL_ONE_MODE = 3'h4,
        COCD_OSC_XT = 3'h5,
        COCD_OSC_HIGH_CRYSTAL_TWO_MODE = 3'h6,
        COCD_OSC_HIGH_CRYSTAL_ONE_MODE = 3'h7
    } cocd_osc_mode_t;
    // brown-out qualify state machine, gray coded
    typedef enum logic [1:0] {
        COCD_BOR_OK = 2'h0,
        COCD_BOR_DIP = 2'h1,
        COCD_BOR_TRIP = 2'h3
    } cocd_bor_state_t;
endpackage

// ### test/cocd_chk.sv
// concurrent checks on the configuration decoder ports
`timescale 1ns/1ps
module cocd_chk
    import cocd_pkg::*;
(
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // live inputs
    input wire cocd_pkg::cocd_cpu_mode_t cpu_mode,
    input wire logic supply_below_trip,
    input wire logic [11:0] adc_result,
    // decoded settings
    input wire logic [1:0] brownout_level_select,
    input wire logic brownout_enable,
    input wire logic brownout_reset,
    input wire logic watchdog_enable,
    input wire logic glitch_filter_on,
    input wire logic [5:0] glitch_width,
    input wire logic [5:0] fast_rc_trim,
    input wire logic [2:0] main_osc_select,
    input wire logic main_is_rc,
    input wire logic clock_out_enable,
    input wire logic adc_result_align,
    input wire logic [7:0] adc_result_high,
    input wire logic [7:0] adc_result_low
);
    // =====
    // helper state: edges since release, dip length, last adc sample
    typedef struct packed {
        logic [1:0] up;
        logic [11:0] dip;
        logic [11:0] adc_q;
    } cocd_chk_st_t;
    cocd_chk_st_t st, next_st;
    // dip count saturates so a long dip never wraps back to short
    always_comb begin
        next_st = st;
        if (st.up != 2'h3)
            next_st.up = st.up + 2'h1;
        next_st.dip = !supply_below_trip ? 12'h000 :
            (&st.dip ? st.dip : st.dip + 12'h001);
        next_st.adc_q = adc_result;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =====
    // sequences
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_quiet;
        !supply_below_trip [*3];
    endsequence
    // =====
    // properties
    AST_APB_READY: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    AST_APB_PULSE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_WRITE_REFUSED: assert property (
        (psel && penable && pready && pwrite) |-> pslverr)
        else $error("write not refused");
    AST_BOR_ENABLE: assert property (
        brownout_enable == (brownout_level_select != 2'h3))
        else $error("brownout enable wrong");
    AST_BOR_SHORT: assert property (
        (st.dip > 12'd4 && st.dip < 12'd990) |-> !brownout_reset)
        else $error("short dip caused reset");
    AST_BOR_LONG: assert property (
        (st.dip > 12'd1010 && brownout_enable) |-> brownout_reset)
        else $error("long dip gave no reset");
    AST_BOR_RELEASE: assert property (s_quiet |-> !brownout_reset)
        else $error("reset outlived the dip");
    AST_FILTER_OFF: assert property (
        cpu_mode != COCD_CPU_NORMAL |=> !glitch_filter_on)
        else $error("filter on in low mode");
    AST_LXT_WIDTH: assert property (
        main_osc_select == 3'h4 |=> glitch_width == 6'h08)
        else $error("low crystal width wrong");
    AST_CLOCK_OUT: assert property (
        clock_out_enable |-> main_is_rc && !main_osc_select[2])
        else $error("clock out outside rc mode");
    AST_ADC_LOW: assert property (
        !adc_result_align ##1 !adc_result_align |->
        adc_result_high == {4'h0, st.adc_q[11:8]} &&
        adc_result_low == st.adc_q[7:0])
        else $error("adc low layout wrong");
    AST_ADC_HIGH: assert property (
        adc_result_align ##1 adc_result_align |->
        adc_result_high == st.adc_q[11:4] &&
        adc_result_low == {4'h0, st.adc_q[3:0]})
        else $error("adc high layout wrong");
    AST_HELD: assert property (st.up == 2'h3 |->
        $stable({fast_rc_trim, main_osc_select, watchdog_enable}))
        else $error("setting changed after capture");
endmodule

bind cocd_decoder cocd_chk u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
    .cpu_mode, .supply_below_trip, .adc_result, .brownout_level_select,
    .brownout_enable, .brownout_reset, .watchdog_enable,
    .glitch_filter_on, .glitch_width, .fast_rc_trim, .main_osc_select,
    .main_is_rc, .clock_out_enable, .adc_result_align,
    .adc_result_high, .adc_result_low
);

// ### test/tb_top.sv
// self-checking bench for the configuration decoder
`timescale 1ns/1ps
`include "cocd_defines.svh"
module tb_top;
    import cocd_pkg::*;
    // =====
    // design signals
    logic pclk, presetn, psel, penable, pwrite, supply_below_trip;
    logic [11:0] paddr, adc_result;
    logic [31:0] pwdata, prdata, d;
    logic [14:0] otp_word0, otp_word1, otp_word2, otp_word3;
    cocd_cpu_mode_t cpu_mode;
    logic pready, pslverr, e, reset_speed_select, power_tier_select;
    logic brownout_enable, brownout_reset, ext_reset_pin_select;
    logic pin57_pullup_ctl_init, watchdog_enable, watchdog_clk_16k;
    logic glitch_filter_on, code_protect, sub_crystal_mode, sub_rc_32k;
    logic sub_pins_io, main_is_rc, clock_out_pin_io, clock_out_enable;
    logic rc_reference_select, i2c_pin_route, input_lowpass_strength;
    logic adc_result_align;
    logic [1:0] brownout_level_select, fast_rc_freq_select;
    logic [2:0] main_osc_select;
    logic [3:0] slow_rc_trim;
    logic [5:0] glitch_width, fast_rc_trim, customer_tag;
    logic [7:0] adc_result_high, adc_result_low;
    logic [14:0] cfg [3][4];
    logic [14:0] w [4];
    int fail_count, cmp_count;
    cocd_decoder DUT (.*);
    // =====
    // clock, 5 ns period
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // =====
    // tasks
    task automatic chk(input string n, input logic [31:0] s, x);
        cmp_count++;
        if (s !== x) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    // one apb transfer; waits on pready with a bound
    task automatic apb(input logic wr, input logic [11:0] a);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {32{wr}};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            fail_count++;
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one configuration: reset, read back, decode, live paths
    task automatic run_set();
        logic [5:0] gw;
        gw = (!w[0][4] || w[1][3:1] == 3'h4) ? 6'h08 : 6'h20;
        @(posedge pclk);
        presetn <= 1'b0;
        {otp_word0, otp_word1, otp_word2, otp_word3} <=
            {w[0], w[1], w[2], w[3]};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        // second pass runs with the otp inputs inverted
        for (int p = 0; p < 8; p++) begin
            if (p == 4)
                {otp_word0, otp_word1, otp_word2, otp_word3} <=
                    ~{w[0], w[1], w[2], w[3]};
            apb(1'b0, 12'(4 * (p % 4)));
            chk("word", d, {17'h0, w[p % 4]});
        end
        apb(1'b1, 12'h000);
        chk("write_err", e, 1'b1);
        apb(1'b0, 12'h000);
        chk("word0_kept", d, {17'h0, w[0]});
        apb(1'b0, 12'h014);
        chk("unmapped", {e, d[30:0]}, 32'h80000000);
        chk("speed", reset_speed_select, w[0][10]);
        chk("power", power_tier_select, w[0][9]);
        chk("bor_sel", {brownout_level_select, brownout_enable},
            {w[0][8:7], w[0][8:7] != 2'h3});
        chk("rst_pin", {ext_reset_pin_select, pin57_pullup_ctl_init},
            {w[0][6], w[0][6]});
        chk("wdt_en", watchdog_enable, !w[0][5]);
        chk("wdt_clk", watchdog_clk_16k, 1'b1);
        chk("protect", code_protect, w[0][2:0] == 3'h0);
        chk("sub", {sub_crystal_mode, sub_rc_32k, sub_pins_io},
            {!w[1][14], w[1][14] & !w[1][13], w[1][14]});
        chk("fast_rc", {fast_rc_trim, fast_rc_freq_select},
            w[1][12:5]);
        chk("main", {main_osc_select, main_is_rc, clock_out_pin_io},
            {w[1][3:1], !w[1][3], !w[1][3] & w[1][1]});
        chk("ckout", clock_out_enable, !w[1][3] & w[1][0]);
        chk("slow_rc", slow_rc_trim, w[2][11:8]);
        chk("ref", rc_reference_select, w[2][6]);
        chk("i2c", i2c_pin_route, w[2][4]);
        chk("lpf", input_lowpass_strength, w[3][14]);
        chk("align", adc_result_align, w[3][11]);
        chk("tag", customer_tag, w[3][5:0]);
        chk("width", glitch_width, gw);
        apb(1'b0, 12'h010);
        chk("status", d, {25'h0, gw, 1'b0});
        for (int m = 0; m < 4; m++) begin
            cpu_mode <= cocd_cpu_mode_t'(m);
            repeat (2) @(posedge pclk);
            chk("filter", glitch_filter_on, w[0][3] && m == 0);
        end
        adc_result <= 12'hA5C;
        repeat (3) @(posedge pclk);
        chk("adc_high", adc_result_high, w[3][11] ? 8'hA5 : 8'h0A);
        chk("adc_low", adc_result_low, w[3][11] ? 8'h0C : 8'h5C);
        apb(1'b0, 12'h018);
        chk("adc_reg", d, w[3][11] ? 32'hA50C : 32'h0A5C);
        // a dip just short of the qualifying time, then a long one
        for (int j = 0; j < 2; j++) begin
            supply_below_trip <= 1'b1;
            repeat (j ? 1100 : 900) @(posedge pclk);
            chk("bor", brownout_reset, j && w[0][8:7] != 2'h3);
            supply_below_trip <= 1'b0;
            repeat (4) @(posedge pclk);
            chk("bor_end", brownout_reset, 1'b0);
        end
    endtask
    // =====
    // watchdog against a hang
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
    // =====
    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, supply_below_trip} = 4'h0;
        {paddr, adc_result, pwdata} = '0;
        {otp_word0, otp_word1, otp_word2, otp_word3} = '0;
        cpu_mode = COCD_CPU_NORMAL;
        // spare bits of the first word stay at one in every set
        cfg = '{'{15'h7810, 15'h1538, 15'h3582, 15'h37D5},
            '{15'h7FEF, 15'h4AD3, 15'h3AD2, 15'h7FEA},
            '{`COCD_W0_RESET, `COCD_W1_RESET, `COCD_W2_RESET,
            `COCD_W3_RESET}};
        for (int i = 0; i < 3; i++) begin
            w = cfg[i];
            run_set();
        end
        end_of_test();
    end
endmodule
